//--- include/sio_pkg.sv
// shared constants, carriers and states of the synchronous serial block
package sio_pkg;

   // transfer mode field codes
   localparam logic [1:0] MODE_TX   = 2'h0;
   localparam logic [1:0] MODE_RX   = 2'h1;
   localparam logic [1:0] MODE_TRX  = 2'h2;
   localparam logic [1:0] MODE_RSVD = 2'h3;

   // clock select codes
   localparam logic [2:0] CLK_SLOW = 3'h0;
   localparam logic [2:0] CLK_EXT  = 3'h7;

   // half-period reload values in high-frequency clock cycles, minus one
   localparam logic [10:0] HALF_DIV12 = 11'h7FF;
   localparam logic [10:0] HALF_DIV8  = 11'h07F;
   localparam logic [10:0] HALF_DIV7  = 11'h03F;
   localparam logic [10:0] HALF_DIV6  = 11'h01F;
   localparam logic [10:0] HALF_DIV5  = 11'h00F;
   localparam logic [10:0] HALF_DIV4  = 11'h007;
   localparam logic [10:0] HALF_DIV3  = 11'h003;
   // half period of the low-frequency divided clock, in low-frequency ticks minus one
   localparam logic [10:0] HALF_FS    = 11'h007;

   // bit counter value at the eighth falling edge of a byte
   localparam logic [2:0] BIT_LAST  = 3'h7;
   localparam logic [2:0] BIT_FIRST = 3'h1;

   // buffer reset values
   localparam logic [7:0] RX_BUF_RESET = 8'h00;
   localparam logic [7:0] TX_BUF_RESET = 8'h00;

   // control bits written by software
   typedef struct packed {
      logic       start;
      logic       force_stop;
      logic [1:0] mode;
      logic       order;
      logic [2:0] clk_sel;
   } ctrl_s;

   // status bits read by software
   typedef struct packed {
      logic busy;
      logic shift_in_progress_flag;
      logic tx_buffer_empty_flag;
      logic rxf;
      logic txerr;
      logic rxerr;
   } status_s;

   localparam status_s STATUS_RESET = '{busy: 1'b0, shift_in_progress_flag: 1'b0, tx_buffer_empty_flag: 1'b1,
                                        rxf: 1'b0, txerr: 1'b0, rxerr: 1'b0};

   // byte phase
   typedef enum logic [2:0] {
      PH_IDLE  = 3'b001,
      PH_SHIFT = 3'b010,
      PH_TAIL  = 3'b100
   } phase_e;

endpackage : sio_pkg

//--- design/sio_clkgen.sv
// internal serial clock divider with idle-high output and edge pulses
`timescale 1ns/1ps
`default_nettype none
module sio_clkgen
   import sio_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // selection
   input  wire logic       run,
   input  wire logic [2:0] clk_sel,
   input  wire logic       use_fs,
   input  wire logic       fs_tick,
   // divided clock
   output var  logic       sck,
   output var  logic       fall_ev,
   output var  logic       rise_ev
);

   logic [10:0] cnt;
   wire  logic [10:0] limit;
   wire  logic        tick;
   wire  logic        wrap;

   // reload value per clock select code
   function automatic logic [10:0] half_limit(input logic [2:0] code);
      case (code)
         3'h1:    half_limit = HALF_DIV8;
         3'h2:    half_limit = HALF_DIV7;
         3'h3:    half_limit = HALF_DIV6;
         3'h4:    half_limit = HALF_DIV5;
         3'h5:    half_limit = HALF_DIV4;
         3'h6:    half_limit = HALF_DIV3;
         default: half_limit = HALF_DIV12;
      endcase
   endfunction : half_limit

   // source selection
   assign limit = use_fs ? HALF_FS : half_limit(clk_sel);
   assign tick  = use_fs ? fs_tick : 1'b1;
   assign wrap  = tick && (cnt == limit);

   always_ff @(posedge clk) begin
      if (!reset_n || !run) begin
         cnt     <= 11'h000;
         sck     <= 1'b1;
         fall_ev <= 1'b0;
         rise_ev <= 1'b0;
      end else begin
         fall_ev <= wrap && sck;
         rise_ev <= wrap && !sck;
         if (wrap) begin
            cnt <= 11'h000;
            sck <= !sck;
         end else if (tick) begin
            cnt <= cnt + 11'h001;
         end
      end
   end

endmodule : sio_clkgen
`default_nettype wire

//--- design/sio_edge_sync.sv
// synchroniser and edge detector for the external serial clock
`timescale 1ns/1ps
`default_nettype none
module sio_edge_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // pin
   input  wire logic pin,
   // edge pulses
   output var  logic fall_ev,
   output var  logic rise_ev
);

   logic meta;
   logic stable;
   logic prev;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         meta   <= 1'b1;
         stable <= 1'b1;
         prev   <= 1'b1;
      end else begin
         meta   <= pin;
         stable <= meta;
         prev   <= stable;
      end
   end

   // edges seen only behind the second stage
   assign fall_ev = prev && !stable;
   assign rise_ev = !prev && stable;

endmodule : sio_edge_sync
`default_nettype wire

//--- design/sio_core.sv
// synchronous serial interface: clocking, bit order, modes and transfer start
//
// Summary of operation
// - codes other than 111B drive the divided clock out on the clock pin
// - with internal clock the clock pin stays high outside transfers
// - codes 000 to 110 pick divisors; low-speed modes allow only 000 and external code 111
// - internal clock stops while the buffer is unserviced
// - clock resumes within one serial period after the buffer access
// - code 111B takes the clock from the pin and drives none
// - transmit on falling pin edge, sample receive on rising edge
// - one bit-order setting serves transmit and receive
// - order 0 sends bit 7 first, order 1 sends bit 0 first
// - mode 00B is transmit only
// - a transmit buffer write clears the empty flag
// - busy rises with the first falling edge after start
// - transmit shifts one bit per falling edge in chosen order
// - shift flag high from first to eighth falling edge
// - empty flag set at next rise after load, interrupt at next fall
// - in transmit modes the internal clock waits for a written byte before starting
// - internal clock loads and starts within one serial period
// - external clock loads at the first fall after start
// - mode 01B receive, 10B both directions, 11B reserved
// - writes while the buffer is full are dropped
// - force stop halts at once and resets start, status and buffers
`timescale 1ns/1ps
`default_nettype none
module sio_core
   import sio_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // control bits
   input  wire ctrl_s      ctrl,
   input  wire logic       timebase_divider_select,
   input  wire logic       low_speed_mode,
   input  wire logic       fs_tick,
   // buffer access
   input  wire logic       tx_write,
   input  wire logic [7:0] tx_data,
   input  wire logic       rx_read,
   input  wire logic       txerr_clear,
   input  wire logic       rxerr_clear,
   // status and results
   output var  status_s    status,
   output var  logic [7:0] receive_buffer,
   output var  logic       serial_interrupt_request,
   output var  logic       start_bit_clear,
   // serial pins
   input  wire logic       sck_in,
   output var  logic       sck_out,
   output var  logic       sck_oe,
   input  wire logic       si_in,
   output var  logic       so_out
);

   // state
   phase_e     phase;
   logic [2:0] bit_cnt;
   logic [7:0] tx_buffer;
   logic [7:0] tx_shift;
   logic [7:0] rx_shift;
   logic       tx_loaded;
   logic       tx_irq_pend;
   logic       err_irq_pend;

   // next values
   phase_e     next_phase;
   status_s    next_status;
   logic [2:0] next_cnt;
   logic [7:0] next_txbuf;
   logic [7:0] next_tx_shift;
   logic [7:0] next_rx_shift;
   logic [7:0] next_rxbuf;
   logic       next_so;
   logic       next_irq;
   logic       next_loaded;
   logic       next_tx_pend;
   logic       next_err_pend;

   // decode wires
   wire logic ext_mode;
   wire logic tx_mode;
   wire logic rx_mode;
   wire logic mode_ok;
   wire logic clk_ok;
   wire logic use_fs;
   wire logic go;
   wire logic run;
   wire logic int_fall;
   wire logic int_rise;
   wire logic ext_fall;
   wire logic ext_rise;
   wire logic fall_ev;
   wire logic rise_ev;
   wire logic start_now;
   wire logic underrun;
   wire logic first_rise;
   wire logic first_bit;
   wire logic [7:0] tx_next_shift;

   // bit presented on the data pin for a given shifter content
   // msb or lsb first
   function automatic logic pick(input logic [7:0] data, input logic lsb_first);
      pick = lsb_first ? data[0] : data[7];
   endfunction : pick

   // shifter after one transmit step
   function automatic logic [7:0] advance(input logic [7:0] data, input logic lsb_first);
      advance = lsb_first ? {1'b0, data[7:1]} : {data[6:0], 1'b0};
   endfunction : advance

   // shifter after one received bit
   function automatic logic [7:0] shift_in(input logic [7:0] data, input logic bit_in,
                                           input logic lsb_first);
      shift_in = lsb_first ? {bit_in, data[7:1]} : {data[6:0], bit_in};
   endfunction : shift_in

   assign tx_mode = (ctrl.mode == MODE_TX) || (ctrl.mode == MODE_TRX);
   assign rx_mode = (ctrl.mode == MODE_RX) || (ctrl.mode == MODE_TRX);
   assign mode_ok = ctrl.mode != MODE_RSVD;

   assign ext_mode = ctrl.clk_sel == CLK_EXT;
   assign clk_ok   = !low_speed_mode || (ctrl.clk_sel == CLK_SLOW);
   assign use_fs   = (ctrl.clk_sel == CLK_SLOW) && (timebase_divider_select || low_speed_mode);

   assign go = ctrl.start && mode_ok && clk_ok && !(tx_mode && status.tx_buffer_empty_flag)
               && !(rx_mode && status.rxf);

   assign run = !ext_mode && !ctrl.force_stop && ((phase != PH_IDLE) || go);

   // edge source
   assign fall_ev = ext_mode ? ext_fall : int_fall;
   assign rise_ev = ext_mode ? ext_rise : int_rise;

   assign start_now = fall_ev && (phase == PH_IDLE) && ctrl.start && mode_ok
                      && (ext_mode || go);
   assign underrun  = start_now && tx_mode && status.tx_buffer_empty_flag;
   assign first_rise = rise_ev && (phase == PH_SHIFT) && (bit_cnt == BIT_FIRST);
   assign first_bit     = pick(tx_buffer, ctrl.order);
   assign tx_next_shift = advance(tx_shift, ctrl.order);

   // internal divided clock
   sio_clkgen u_clkgen (
      .clk     (clk),
      .reset_n (reset_n),
      .run     (run),
      .clk_sel (ctrl.clk_sel),
      .use_fs  (use_fs),
      .fs_tick (fs_tick),
      .sck     (sck_out),
      .fall_ev (int_fall),
      .rise_ev (int_rise)
   );

   // external clock edges
   sio_edge_sync u_edge (
      .clk     (clk),
      .reset_n (reset_n),
      .pin     (sck_in),
      .fall_ev (ext_fall),
      .rise_ev (ext_rise)
   );

   // next-state logic; software clears first so hardware sets win
   always_comb begin
      next_phase    = phase;
      next_status   = status;
      next_cnt      = bit_cnt;
      next_txbuf    = tx_buffer;
      next_tx_shift = tx_shift;
      next_rx_shift = rx_shift;
      next_rxbuf    = receive_buffer;
      next_so       = so_out;
      next_irq      = 1'b0;
      next_loaded   = tx_loaded;
      next_tx_pend  = tx_irq_pend;
      next_err_pend = err_irq_pend;
      if (tx_write && status.tx_buffer_empty_flag) begin
         next_txbuf     = tx_data;
         next_status.tx_buffer_empty_flag = 1'b0;
      end
      if (rx_read) begin
         next_status.rxf = 1'b0;
      end
      if (txerr_clear) begin
         next_status.txerr = 1'b0;
      end
      if (rxerr_clear) begin
         next_status.rxerr = 1'b0;
      end
      if (start_now) begin
         next_phase      = PH_SHIFT;
         next_cnt        = BIT_FIRST;
         next_status.busy = 1'b1;
         next_status.shift_in_progress_flag  = 1'b1;
         next_loaded     = tx_mode && !status.tx_buffer_empty_flag;
         next_so         = 1'b1;
         if (tx_mode && !status.tx_buffer_empty_flag) begin
            next_tx_shift = tx_buffer;
            next_so       = first_bit;
         end
         if (underrun) begin
            next_status.txerr = 1'b1;
            next_err_pend     = 1'b1;
         end
      end else if (fall_ev && (phase == PH_SHIFT)) begin
         next_tx_shift = tx_next_shift;
         if (tx_loaded) begin
            next_so = pick(tx_next_shift, ctrl.order);
         end
         // shift flag ends at eighth fall
         if (bit_cnt == BIT_LAST) begin
            next_phase     = PH_TAIL;
            next_status.shift_in_progress_flag = 1'b0;
            next_cnt       = 3'h0;
         end else begin
            next_cnt = bit_cnt + 3'h1;
         end
      end
      if (fall_ev && (tx_irq_pend || err_irq_pend)) begin
         next_irq      = 1'b1;
         next_tx_pend  = 1'b0;
         next_err_pend = 1'b0;
      end
      if (rise_ev && (phase != PH_IDLE)) begin
         if (rx_mode && !status.rxerr) begin
            next_rx_shift = shift_in(rx_shift, si_in, ctrl.order);
         end
         if (first_rise && tx_loaded) begin
            next_status.tx_buffer_empty_flag = 1'b1;
            next_tx_pend    = 1'b1;
         end
         if (phase == PH_TAIL) begin
            next_phase = PH_IDLE;
            next_so    = 1'b1;
            if (rx_mode && status.rxf && !rx_read) begin
               next_status.rxerr = 1'b1;
               next_irq          = 1'b1;
            end else if (rx_mode && !status.rxerr) begin
               next_rxbuf      = shift_in(rx_shift, si_in, ctrl.order);
               next_status.rxf = 1'b1;
               next_irq        = 1'b1;
            end
         end
      end
      // transfer ends at a byte boundary once start is withdrawn
      if (status.busy && (phase == PH_IDLE) && !start_now && !ctrl.start) begin
         next_status.busy = 1'b0;
      end
      if (ctrl.force_stop) begin
         next_phase    = PH_IDLE;
         next_status   = STATUS_RESET;
         next_cnt      = 3'h0;
         next_txbuf    = TX_BUF_RESET;
         next_rxbuf    = RX_BUF_RESET;
         next_so       = 1'b1;
         next_irq      = 1'b0;
         next_loaded   = 1'b0;
         next_tx_pend  = 1'b0;
         next_err_pend = 1'b0;
      end
   end

   // state registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         phase                    <= PH_IDLE;
         status                   <= STATUS_RESET;
         bit_cnt                  <= 3'h0;
         tx_buffer                <= TX_BUF_RESET;
         tx_shift                 <= TX_BUF_RESET;
         rx_shift                 <= RX_BUF_RESET;
         receive_buffer           <= RX_BUF_RESET;
         so_out                   <= 1'b1;
         serial_interrupt_request <= 1'b0;
         tx_loaded                <= 1'b0;
         tx_irq_pend              <= 1'b0;
         err_irq_pend             <= 1'b0;
      end else begin
         phase                    <= next_phase;
         status                   <= next_status;
         bit_cnt                  <= next_cnt;
         tx_buffer                <= next_txbuf;
         tx_shift                 <= next_tx_shift;
         rx_shift                 <= next_rx_shift;
         receive_buffer           <= next_rxbuf;
         so_out                   <= next_so;
         serial_interrupt_request <= next_irq;
         tx_loaded                <= next_loaded;
         tx_irq_pend              <= next_tx_pend;
         err_irq_pend             <= next_err_pend;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sck_oe          <= 1'b0;
         start_bit_clear <= 1'b0;
      end else begin
         sck_oe          <= !ext_mode;
         start_bit_clear <= ctrl.force_stop;
      end
   end

   // checks on the block's own behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_load_rise;
      first_rise && tx_loaded && !ctrl.force_stop;
   endsequence

   sequence s_empty_set;
      status.tx_buffer_empty_flag && tx_irq_pend;
   endsequence

   sequence s_tx_start;
      start_now && tx_mode && !status.tx_buffer_empty_flag && !ctrl.force_stop;
   endsequence

   a_txf_after_load: assert property (
      s_load_rise |=> s_empty_set)
      else $error("empty flag not set at first rise after load");

   a_irq_on_fall: assert property (
      tx_irq_pend && fall_ev && !ctrl.force_stop |=> serial_interrupt_request)
      else $error("interrupt missing at fall after empty flag");

   a_write_clears: assert property (
      tx_write && status.tx_buffer_empty_flag && !ctrl.force_stop |=> !status.tx_buffer_empty_flag && tx_buffer == $past(tx_data))
      else $error("write did not fill buffer and clear empty flag");

   a_write_dropped: assert property (
      tx_write && !status.tx_buffer_empty_flag && !ctrl.force_stop |=> tx_buffer == $past(tx_buffer))
      else $error("write accepted while buffer full");

   a_first_bit: assert property (
      s_tx_start |=> so_out == $past(first_bit) && status.busy && status.shift_in_progress_flag)
      else $error("first bit or busy wrong at transfer start");

   a_sef_eight: assert property (
      $fell(status.shift_in_progress_flag) && !$past(ctrl.force_stop) |-> $past(bit_cnt) == BIT_LAST)
      else $error("shift flag dropped before eighth fall");

   a_so_on_edges: assert property (
      !fall_ev && !rise_ev && !ctrl.force_stop |=> $stable(so_out))
      else $error("data pin moved without a clock edge");

   a_wait_high: assert property (
      !ext_mode && !run ##1 !ext_mode && !run |-> sck_out)
      else $error("internal clock not parked high while stopped");

   a_ext_released: assert property (
      ext_mode [*2] |-> !sck_oe && !int_fall)
      else $error("clock pin driven in external mode");

   a_force_stop: assert property (
      ctrl.force_stop |=> status == STATUS_RESET && phase == PH_IDLE && start_bit_clear)
      else $error("force stop did not reset state");

endmodule : sio_core
`default_nettype wire

//--- sim/sio_far_model.sv
// far-side serial device: clock source in external mode, byte capture, data source
`timescale 1ns/1ps
`default_nettype none
module sio_far_model (
   // clock and control
   input  wire logic       clk,
   input  wire logic       arm,
   input  wire logic       ext,
   input  wire logic [7:0] rx_byte,
   // pins
   input  wire logic       pin,
   input  wire logic       so,
   output var  logic       drv_sck,
   output var  logic       si,
   output var  logic [7:0] cap
);
   int cnt;
   initial begin
      drv_sck = 1'b1;
      si = 1'b1;
      cap = 8'h00;
      cnt = 0;
   end
   // phase width: eight pulses, six fast cycles low and seven high, still outside frames
   always begin
      wait (arm && ext);
      repeat (8) begin
         @(posedge clk) drv_sck <= 1'b0;
         repeat (6) @(posedge clk);
         drv_sck <= 1'b1;
         repeat (6) @(posedge clk);
      end
      wait (!arm);
   end
   // rising pin edge captures data out; disarming clears the bit count
   always @(posedge pin or negedge arm) begin
      if (!arm) begin
         cnt <= 0;
      end else begin
         cap <= {cap[6:0], so};
         cnt <= cnt + 1;
      end
   end
   // falling pin edge presents next bit; released line shows the inverse
   always @(negedge pin) si <= (arm && cnt < 8) ? rx_byte[7 - cnt] : ~si;
endmodule : sio_far_model
`default_nettype wire

//--- sim/sio_core_test.sv
// self-checking bench for the synchronous serial core
`timescale 1ns/1ps
`default_nettype none
module sio_core_test;
   import sio_pkg::*;
   typedef struct packed {
      logic [2:0] sel;
      logic       order;
      logic [1:0] mode;
      logic [7:0] tx;
      logic [7:0] rx;
   } row_s;
   logic       clk, reset_n, tds, low_speed_mode, fs_tick, tx_write, rx_read;
   logic       irq, start_bit_clear, sck_out, sck_oe, so_out, si, drv_sck, pin, arm;
   logic [7:0] tx_data, receive_buffer, rx_byte, cap;
   ctrl_s      ctrl;
   status_s    status;
   int         mismatches, checks_done, cycles, ticks, n, irqs;
   row_s       rows [5] = '{'{3'h6, 1'b0, MODE_TX, 8'hA5, 8'h00},
                            '{3'h5, 1'b1, MODE_TRX, 8'h3C, 8'h96},
                            '{3'h7, 1'b0, MODE_TRX, 8'hC1, 8'h5A},
                            '{3'h7, 1'b1, MODE_RX, 8'h00, 8'hE7},
                            '{3'h0, 1'b1, MODE_TRX, 8'h81, 8'h42}};
   // pin level from the driving party
   assign pin = sck_oe ? sck_out : drv_sck;
   sio_core u_dut (.clk(clk), .reset_n(reset_n), .ctrl(ctrl),
      .timebase_divider_select(tds), .low_speed_mode(low_speed_mode), .fs_tick(fs_tick),
      .tx_write(tx_write), .tx_data(tx_data), .rx_read(rx_read), .txerr_clear(1'b0),
      .rxerr_clear(1'b0), .status(status), .receive_buffer(receive_buffer),
      .serial_interrupt_request(irq), .start_bit_clear(start_bit_clear), .sck_in(pin),
      .sck_out(sck_out), .sck_oe(sck_oe), .si_in(si), .so_out(so_out));
   sio_far_model u_far (.clk(clk), .arm(arm), .ext(ctrl.clk_sel == CLK_EXT),
      .rx_byte(rx_byte), .pin(pin), .so(so_out), .drv_sck(drv_sck), .si(si), .cap(cap));
   // clock
   initial clk = 1'b0;
   always #2 clk = ~clk;
   // low-frequency tick every fourth cycle and hang guard
   always @(posedge clk) begin
      ticks <= ticks + 1;
      irqs <= irqs + int'(irq);
      fs_tick <= (ticks % 4 == 0);
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic step(input int k);
      repeat (k) @(posedge clk);
   endtask : step
   task automatic wait_busy(input logic v);
      int k;
      k = 0;
      while (status.busy !== v && k < 6000) begin
         step(1);
         k++;
      end
      chk("busy", {7'h00, v}, {7'h00, status.busy});
   endtask : wait_busy
   task automatic put(input logic [7:0] d);
      tx_write <= 1'b1;
      tx_data <= d;
      step(1);
      tx_write <= 1'b0;
      step(1);
   endtask : put
   function automatic logic [7:0] rev(input logic [7:0] x);
      for (int i = 0; i < 8; i++) rev[i] = x[7 - i];
   endfunction : rev
   task automatic run(input row_s r);
      int base;
      int want;
      base = irqs;
      want = int'(r.mode != MODE_RX) + int'(r.mode != MODE_TX);
      ctrl.clk_sel <= r.sel;
      ctrl.order <= r.order;
      ctrl.mode <= r.mode;
      tds <= (r.sel == CLK_SLOW);
      rx_byte <= r.rx;
      step(1);
      if (r.mode != MODE_RX) put(r.tx);
      step(1);
      if (r.mode != MODE_RX) chk("txf low", 8'h00, {7'h00, status.tx_buffer_empty_flag});
      ctrl.start <= 1'b1;
      step(1);
      arm <= 1'b1;
      wait_busy(1'b1);
      ctrl.start <= 1'b0;
      wait_busy(1'b0);
      step(2);
      if (r.mode != MODE_RX) chk("tx byte", r.order ? rev(r.tx) : r.tx, cap);
      if (r.mode != MODE_RX) chk("txf high", 8'h01, {7'h00, status.tx_buffer_empty_flag});
      if (r.mode != MODE_TX) chk("rx byte", r.order ? rev(r.rx) : r.rx, receive_buffer);
      chk("idle high", 8'h01, {7'h00, sck_out});
      chk("irq count", 8'(want), 8'(irqs - base));
      chk("pin drive", {7'h00, r.sel != CLK_EXT}, {7'h00, sck_oe});
      rx_read <= 1'b1;
      step(1);
      rx_read <= 1'b0;
      arm <= 1'b0;
      step(2);
      $display("row sel %h order %b mode %h done", r.sel, r.order, r.mode);
   endtask : run
   // main sequence
   initial begin
      reset_n = 1'b0;
      ctrl = '0;
      {tds, low_speed_mode, fs_tick, tx_write, rx_read, arm} = '0;
      {tx_data, rx_byte} = '0;
      {mismatches, checks_done, cycles, ticks, irqs} = '0;
      step(4);
      reset_n <= 1'b1;
      step(2);
      chk("status", {2'b00, STATUS_RESET}, {2'b00, status});
      chk("sck idle", 8'h01, {7'h00, sck_out});
      chk("so idle", 8'h01, {7'h00, so_out});
      $display("test reset done");
      foreach (rows[i]) run(rows[i]);
      // start without a byte waits, late write resumes, full-buffer write dropped
      ctrl <= '{start: 1'b1, force_stop: 1'b0, mode: MODE_TX, order: 1'b0, clk_sel: 3'h6};
      tds <= 1'b0;
      step(1);
      arm <= 1'b1;
      step(40);
      chk("wait sck", 8'h01, {7'h00, sck_out});
      chk("wait busy", 8'h00, {7'h00, status.busy});
      put(8'h96);
      put(8'h11);
      n = 1;
      while (sck_out !== 1'b0 && n < 20) begin
         step(1);
         n++;
      end
      chk("resume", 8'h01, {7'h00, n <= 7});
      wait_busy(1'b1);
      ctrl.start <= 1'b0;
      wait_busy(1'b0);
      step(2);
      chk("kept byte", 8'h96, cap);
      arm <= 1'b0;
      $display("test auto wait done");
      // force stop in mid-byte
      put(8'hF0);
      ctrl.start <= 1'b1;
      wait_busy(1'b1);
      step(6);
      ctrl.force_stop <= 1'b1;
      step(1);
      ctrl.force_stop <= 1'b0;
      ctrl.start <= 1'b0;
      step(1);
      chk("stop clear", 8'h01, {7'h00, start_bit_clear});
      step(1);
      chk("stop status", {2'b00, STATUS_RESET}, {2'b00, status});
      chk("stop sck", 8'h01, {7'h00, sck_out});
      $display("test force stop done");
      // divisor code 110 in low-speed mode never starts
      low_speed_mode <= 1'b1;
      put(8'h33);
      ctrl.start <= 1'b1;
      step(100);
      chk("slow busy", 8'h00, {7'h00, status.busy});
      chk("slow sck", 8'h01, {7'h00, sck_out});
      ctrl.start <= 1'b0;
      low_speed_mode <= 1'b0;
      $display("test low speed done");
      step(2);
      // reserved transfer mode never starts
      ctrl.mode <= MODE_RSVD;
      ctrl.start <= 1'b1;
      step(100);
      chk("rsvd busy", 8'h00, {7'h00, status.busy});
      chk("rsvd sck", 8'h01, {7'h00, sck_out});
      ctrl.start <= 1'b0;
      $display("test reserved mode done");
      step(2);
      stop_test();
   end
endmodule : sio_core_test
`default_nettype wire
